/* File: common/qdac_pkg.sv */
package qdac_pkg;

    // serial word layout
    localparam int WORD_W = 12;
    localparam int CODE_W = 8;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int CS_HI_BIT = 11;  // word_bit_11
    localparam int CS_LO_BIT = 10;  // word_bit_10
    localparam int ADDR_LO_BIT = 9;  // word_bit_9, lower channel index bit
    localparam int ADDR_UP_BIT = 8;  // word_bit_8, upper channel index bit
    localparam int CODE_MSB = 7;  // code_msb
    localparam int CODE_LSB = 0;  // code_lsb

    // reset values
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;

    // pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    // timing figures of the serial link
    localparam int REF_PERIOD_NS = 5;
    localparam int SCK_MAX_MHZ = 10;
    localparam int RST_TO_LOAD_NS = 50;
    localparam int RST_TO_LOAD_CYC = (RST_TO_LOAD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    // load sequencer states
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_IDLE = 2'b01,
        ST_LOAD = 2'b10,
        ST_SKIP = 2'b11
    } qdac_state_e;

endpackage : qdac_pkg

/* File: core/qdac_shift.sv */
`timescale 1ns/100ps
`default_nettype none

// serial shift register, runs on the serial clock itself
module qdac_shift
    import qdac_pkg::*;
#(
    parameter int W = WORD_W
) (
    input wire logic ser_clk,
    input wire logic sys_rst,
    input wire logic serial_in,
    output logic [W-1:0] shift_word
);

    logic rst_s1;
    logic link_rst;

    // reset carried into the link domain; it only acts while the clock runs
    always_ff @(posedge ser_clk) begin
        rst_s1 <= sys_rst;
        link_rst <= rst_s1;
    end

    // msb first: older bits move up, the newest lands in bit 0
    always_ff @(posedge ser_clk) begin
        if (link_rst) begin
            shift_word <= '0;
        end else begin
            shift_word <= {shift_word[W-2:0], serial_in};
        end
    end

    shift_order_a: assert property (@(posedge ser_clk) disable iff (link_rst)
        !$past(link_rst) |-> shift_word == {$past(shift_word[W-2:0]), $past(serial_in)})
        else $error("shift register did not take serial_in into bit 0");

    msb_travel_a: assert property (@(posedge ser_clk) disable iff (link_rst)
        !$past(link_rst, W) && !$past(link_rst) |-> shift_word[W-1] == $past(serial_in, W))
        else $error("first bit did not reach the top after twelve edges");

endmodule : qdac_shift

`default_nettype wire

/* File: core/qdac_top.sv */
`timescale 1ns/100ps
`default_nettype none

module qdac_top
    import qdac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ser_clk,
    input wire logic serial_in,
    input wire logic load_strobe,
    input wire logic chip_sel_pin_hi,
    input wire logic chip_sel_pin_lo,
    input wire logic force_rst_n,
    output logic [CODE_W-1:0] analog_out_1,
    output logic [CODE_W-1:0] analog_out_2,
    output logic [CODE_W-1:0] analog_out_3,
    output logic [CODE_W-1:0] analog_out_4,
    output logic load_busy,
    output logic load_ignored,
    output logic reset_active
);

    // pin index inside the synchroniser bank
    localparam int P_LOAD = 0;
    localparam int P_CSLO = 1;
    localparam int P_CSHI = 2;
    localparam int P_NRST = 3;
    localparam int NPIN = 4;

    // channel index from the two address bits; bit 8 is the upper index bit
    function automatic logic [CH_W-1:0] chan_of(input logic [WORD_W-1:0] w);
        chan_of = {w[ADDR_UP_BIT], w[ADDR_LO_BIT]};
    endfunction : chan_of

    // chip-select bits of the word against the strapped pins
    function automatic logic cs_match(input logic [WORD_W-1:0] w, input logic hi,
                                      input logic lo);
        cs_match = (w[CS_HI_BIT] == hi) && (w[CS_LO_BIT] == lo);
    endfunction : cs_match

    logic [WORD_W-1:0] shift_word;
    logic [WORD_W-1:0] word_cap;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin_f;
    logic [NPIN-1:0] next_pin_f;
    logic [CODE_W-1:0] code_q [NUM_CH];
    qdac_state_e state;
    qdac_state_e next_state;

    wire load_lvl;
    wire cs_hi_lvl;
    wire cs_lo_lvl;
    wire nrst_lvl;
    wire in_reset;
    wire word_match;
    wire load_fire;
    wire [CH_W-1:0] sel_chan;
    wire [CODE_W-1:0] sel_code;

    // the shift register lives on the serial clock
    qdac_shift #(
        .W(WORD_W)
    ) u_shift (
        .ser_clk(ser_clk),
        .sys_rst(sys_rst),
        .serial_in(serial_in),
        .shift_word(shift_word)
    );

    assign pin_raw[P_LOAD] = load_strobe;
    assign pin_raw[P_CSLO] = chip_sel_pin_lo;
    assign pin_raw[P_CSHI] = chip_sel_pin_hi;
    assign pin_raw[P_NRST] = force_rst_n;

    // three-stage pin synchronisers; stage one feeds only stage two
    always_ff @(posedge ref_clk) begin
        pin_s1 <= pin_raw;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    // a level change counts once stages two and three agree
    assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));

    // filtered levels start as load low and forced reset asserted
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_f <= 4'h0;
        end else begin
            pin_f <= next_pin_f;
        end
    end

    assign load_lvl = pin_f[P_LOAD];
    assign cs_lo_lvl = pin_f[P_CSLO];
    assign cs_hi_lvl = pin_f[P_CSHI];
    assign nrst_lvl = pin_f[P_NRST];

    // word crossing: the serial clock stands still while load is high, so the
    // captured copy is settled by the time the synchronised load arrives
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            word_cap <= WORD_RESET;
        end else begin
            word_cap <= shift_word;
        end
    end

    // load decode
    assign in_reset = !nrst_lvl;
    assign word_match = cs_match(word_cap, cs_hi_lvl, cs_lo_lvl);
    assign sel_chan = chan_of(word_cap);
    assign sel_code = word_cap[CODE_MSB:CODE_LSB];
    assign load_fire = load_lvl && word_match && !in_reset;

    // channel latches; level sensitive, so a long load rewrites the same value
    always_ff @(posedge ref_clk) begin
        if (sys_rst || in_reset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                code_q[i] <= CODE_RESET;
            end
        end else if (load_fire) begin
            code_q[sel_chan] <= sel_code;
        end
    end

    assign analog_out_1 = code_q[0];
    assign analog_out_2 = code_q[1];
    assign analog_out_3 = code_q[2];
    assign analog_out_4 = code_q[3];

    // sequencer: tracks reset hold and each load window for status
    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (!in_reset) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (in_reset) begin
                    next_state = ST_HOLD;
                end else if (load_lvl && word_match) begin
                    next_state = ST_LOAD;
                end else if (load_lvl) begin
                    next_state = ST_SKIP;
                end
            end
            ST_LOAD, ST_SKIP: begin
                if (in_reset) begin
                    next_state = ST_HOLD;
                end else if (!load_lvl) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // state and registered status outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_HOLD;
            load_busy <= 1'b0;
            load_ignored <= 1'b0;
            reset_active <= 1'b1;
        end else begin
            state <= next_state;
            load_busy <= (next_state == ST_LOAD);
            load_ignored <= (state == ST_IDLE) && (next_state == ST_SKIP);
            reset_active <= (next_state == ST_HOLD);
        end
    end

    // helper: previous latch contents for the hold checks
    logic [CODE_W-1:0] prev_code [NUM_CH];

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            prev_code[i] <= code_q[i];
        end
    end

    load_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        load_fire |=> code_q[$past(sel_chan)] == $past(sel_code))
        else $error("addressed latch did not take the code on load");

    cs_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        load_lvl && !word_match && !in_reset |=>
            code_q[0] == prev_code[0] && code_q[1] == prev_code[1]
            && code_q[2] == prev_code[2] && code_q[3] == prev_code[3])
        else $error("latch changed with mismatched chip select");

    chan_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        load_fire && word_cap[ADDR_UP_BIT] && !word_cap[ADDR_LO_BIT]
            |=> analog_out_3 == $past(word_cap[CODE_MSB:CODE_LSB]))
        else $error("address 10 did not select output 3");

    code_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        load_fire && sel_chan == 2'h0 |=> analog_out_1 == $past(word_cap[CODE_MSB:CODE_LSB]))
        else $error("output 1 code differs from word bits 7 to 0");

    force_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_reset |=> analog_out_1 == CODE_RESET && analog_out_2 == CODE_RESET
            && analog_out_3 == CODE_RESET && analog_out_4 == CODE_RESET)
        else $error("latch not zero during forced reset");

    release_ready_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(in_reset) |-> state == ST_HOLD ##1 state == ST_IDLE && !reset_active
            && analog_out_2 == CODE_RESET)
        else $error("release did not return to idle with zero codes");

    por_clear_a: assert property (@(posedge ref_clk)
        sys_rst |=> analog_out_1 == CODE_RESET && analog_out_4 == CODE_RESET
            && reset_active && !load_busy)
        else $error("power-on reset did not clear the latches");

    other_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        load_fire && sel_chan != 2'h1 |=> analog_out_2 == $past(analog_out_2))
        else $error("unaddressed latch changed on load");

    busy_window_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (load_lvl && word_match && !in_reset && state == ST_IDLE)
            || (load_busy && load_lvl && !in_reset) |=> load_busy)
        else $error("busy flag did not follow an accepted load");

    ignore_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        load_ignored |=> !load_ignored)
        else $error("ignored-load flag longer than one cycle");

    load_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        load_fire && sel_chan == 2'h3);

    skip_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        load_ignored);

    reset_cycle_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        in_reset ##1 !in_reset [*3] ##1 load_fire);

    back_to_back_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(load_lvl) ##[1:200] load_fire);

endmodule : qdac_top

`default_nettype wire

/* File: bench/qdac_host.sv */
`timescale 1ns/100ps
`default_nettype none

// host on the three-wire load bus; its clock runs inside a word and in idle_clocks
module qdac_host (
    output logic ser_clk,
    output logic serial_in,
    output logic load_strobe
);
    initial begin
        ser_clk = 1'b0;
        serial_in = 1'b0;
        load_strobe = 1'b0;
    end

    // free clock edges with load low; the link-side reset only acts on these
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #50 ser_clk = 1'b1;
            #50 ser_clk = 1'b0;
        end
    endtask : idle_clocks

    // last n bits of w msb first, then a load pulse with the clock parked low
    task automatic send(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #50 ser_clk = 1'b1; // 100 ns period, 80 ns would overrun the ceiling
            #50 ser_clk = 1'b0;
        end
        serial_in = ~serial_in; // no stale bit left on a released line
        #50 load_strobe = 1'b1;
        #80 load_strobe = 1'b0;
        #100;
    endtask : send
endmodule : qdac_host

`default_nettype wire

/* File: bench/quad_dac_serial_load_interface_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module quad_dac_serial_load_interface_bench
    import qdac_pkg::*;
;
    logic ref_clk, sys_rst, ser_clk, serial_in, load_strobe;
    logic chip_sel_pin_hi, chip_sel_pin_lo, force_rst_n;
    logic [CODE_W-1:0] analog_out_1, analog_out_2, analog_out_3, analog_out_4;
    logic load_busy, load_ignored, reset_active, ign_seen, busy_seen;
    logic [31:0] seed = 32'h4631;
    logic [31:0] r;
    int fails = 0;
    int n_checks = 0;
    int model[4];

    qdac_top i_qdac_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
        .serial_in(serial_in), .load_strobe(load_strobe), .chip_sel_pin_hi(chip_sel_pin_hi),
        .chip_sel_pin_lo(chip_sel_pin_lo), .force_rst_n(force_rst_n),
        .analog_out_1(analog_out_1), .analog_out_2(analog_out_2),
        .analog_out_3(analog_out_3), .analog_out_4(analog_out_4),
        .load_busy(load_busy), .load_ignored(load_ignored), .reset_active(reset_active));

    qdac_host i_qdac_host (.ser_clk(ser_clk), .serial_in(serial_in), .load_strobe(load_strobe));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // load_ignored pulses one cycle wide and load_busy lasts only the load window, so latch them as they pass
    always @(posedge ref_clk) begin
        if (load_ignored === 1'b1) ign_seen = 1'b1;
        if (load_busy === 1'b1) busy_seen = 1'b1;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic check_all();
        chk("analog_out_1", model[0][7:0], analog_out_1);
        chk("analog_out_2", model[1][7:0], analog_out_2);
        chk("analog_out_3", model[2][7:0], analog_out_3);
        chk("analog_out_4", model[3][7:0], analog_out_4);
    endtask : check_all

    // one word through the host, then the model updates and all latches compare
    task automatic load(input logic [15:0] w, input int n);
        logic hit;
        hit = (w[11:10] == {chip_sel_pin_hi, chip_sel_pin_lo}) && force_rst_n;
        ign_seen = 1'b0;
        busy_seen = 1'b0;
        i_qdac_host.send(w, n);
        if (hit) model[{w[8], w[9]}] = w[7:0];
        @(negedge ref_clk);
        check_all();
        if (force_rst_n) begin
            chk("load_ignored", {7'h00, !hit}, {7'h00, ign_seen});
            chk("load_busy", {7'h00, hit}, {7'h00, busy_seen});
        end
    endtask : load

    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end

    initial begin
        model = '{0, 0, 0, 0};
        sys_rst = 1'b1;
        force_rst_n = 1'b0;
        chip_sel_pin_hi = 1'b0;
        chip_sel_pin_lo = 1'b1;
        i_qdac_host.idle_clocks(3);
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk("reset_active", 8'h01, {7'h00, reset_active});
        check_all();
        force_rst_n = 1'b1;
        i_qdac_host.idle_clocks(2); // link-side reset lets go before the first word
        #60;
        @(negedge ref_clk);
        chk("reset_active", 8'h00, {7'h00, reset_active});
        // every channel, full scale on the first
        for (int ch = 0; ch < 4; ch++) begin
            r = rnd();
            load({6'h01, ch[0], ch[1], (ch == 0) ? 8'hFF : r[7:0]}, 12);
        end
        // the three foreign chip selects must leave all latches alone
        for (int cs = 0; cs < 4; cs++) begin
            r = rnd();
            if (cs != 1) load({4'h0, cs[1:0], r[9:0]}, 12);
        end
        // random straps, as when several devices share the bus
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            @(negedge ref_clk);
            {chip_sel_pin_hi, chip_sel_pin_lo} = r[1:0];
            repeat (6) @(negedge ref_clk);
            load({4'h0, r[2] ? r[1:0] : r[13:12], r[23:14]}, 12);
        end
        // sixteen bits shifted: only the last twelve count
        r = rnd();
        load({4'hA, chip_sel_pin_hi, chip_sel_pin_lo, r[9:0]}, 16);
        // forced reset clears, holds through a load, and lets go cleanly
        @(negedge ref_clk);
        force_rst_n = 1'b0;
        #40;
        model = '{0, 0, 0, 0};
        check_all();
        chk("reset_active", 8'h01, {7'h00, reset_active});
        load({4'h0, chip_sel_pin_hi, chip_sel_pin_lo, 10'h0C3}, 12);
        force_rst_n = 1'b1;
        #60;
        check_all();
        load({4'h0, chip_sel_pin_hi, chip_sel_pin_lo, 10'h15A}, 12);
        tally_and_finish();
    end
endmodule : quad_dac_serial_load_interface_bench

`default_nettype wire
